/* File: testbench/two_wire_register_slave_test.sv */
// bench: host end and device end on one link, a second pair with a wrong identifier
// assumes the design files under verilog/ are compiled first
`timescale 1ns/1ps
`include "twr_defs.svh"
module two_wire_register_slave_test;
  import twr_pkg::*;
  logic      core_clk = 1'b0;
  logic      rst = 1'b1;
  logic      cmd_valid = 1'b0;
  logic      cmd_valid2 = 1'b0;
  logic      cmd_write = 1'b0;
  logic      cmd_use_addr = 1'b0;
  twr_byte_t cmd_addr = 8'h00;
  twr_word_t cmd_wdata = 16'h0000;
  logic      mclk_assured = 1'b1;
  logic      write_only = 1'b0;
  logic      busy = 1'b0;
  logic      cmd_ready, cmd_ready2, rsp_valid, rsp_valid2, rsp_nack, rsp_nack2;
  logic      xfer_active, reg_we, access_refused, reg_we2;
  twr_word_t rsp_rdata, reg_rdata, reg_wdata;
  twr_byte_t reg_addr;
  logic      refused_seen = 1'b0;
  logic      we2_seen = 1'b0;
  twr_word_t regs [256];
  int        fail_count = 0;
  int        total_checks = 0;
  twr_byte_t open_addr [3] = '{8'h6c, 8'h70, 8'h00};
  twr_byte_t rd_addr [3] = '{8'h00, 8'h7f, 8'hff};
  // 50 MHz core clock
  always #10 core_clk = ~core_clk;
  twr_if link ();
  twr_if link2 ();
  twr_host_end #(.QTR_CYC(4)) twr_host_end_inst (.core_clk(core_clk), .rst(rst), .bus(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_use_addr(cmd_use_addr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .mclk_assured(mclk_assured), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .rsp_rdata(rsp_rdata));
  twr_dev_end twr_dev_end_inst (.core_clk(core_clk), .rst(rst), .bus(link),
    .write_only(write_only), .sequencer_busy_flag(busy), .xfer_active(xfer_active),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .access_refused(access_refused));
  // second pair: host addresses another identifier
  twr_host_end #(.QTR_CYC(4), .DEV_ID(8'h22)) twr_host_end_alt_inst (.core_clk(core_clk),
    .rst(rst), .bus(link2), .cmd_valid(cmd_valid2), .cmd_ready(cmd_ready2),
    .cmd_write(cmd_write), .cmd_use_addr(cmd_use_addr), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .mclk_assured(mclk_assured), .rsp_valid(rsp_valid2),
    .rsp_nack(rsp_nack2), .rsp_rdata());
  twr_dev_end twr_dev_end_alt_inst (.core_clk(core_clk), .rst(rst), .bus(link2),
    .write_only(write_only), .sequencer_busy_flag(busy), .xfer_active(), .reg_addr(),
    .reg_rdata(16'h0000), .reg_wdata(), .reg_we(reg_we2), .access_refused());
  twr_link_asserts #(.QTR_CYC(4)) twr_link_asserts_inst (.core_clk(core_clk), .rst(rst),
    .scl(link.scl), .sda(link.sda), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));
  // register map beside the device end, sticky notes of pulses
  assign reg_rdata = regs[reg_addr];
  always @(posedge core_clk) begin
    if (reg_we === 1'b1)
      regs[reg_addr] <= reg_wdata;
    if (access_refused === 1'b1)
      refused_seen <= 1'b1;
    if (reg_we2 === 1'b1)
      we2_seen <= 1'b1;
  end
  function automatic twr_word_t pre(input twr_byte_t a);
    return {a, ~a};
  endfunction : pre
  task automatic cmp_w(input string what, input twr_word_t exp, input twr_word_t got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_w
  task automatic cmp_b(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_b
  // one command on the host user port, waits for its answer
  task automatic run(input logic w, input logic ua, input twr_byte_t a, input twr_word_t d,
                     input logic alt);
    int n = 0;
    cmd_write = w;
    cmd_use_addr = ua;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = ~alt;
    cmd_valid2 = alt;
    @(posedge core_clk);
    #2;
    cmd_valid = 1'b0;
    cmd_valid2 = 1'b0;
    do begin
      @(posedge core_clk);
      #2;
      n++;
    end while (n < 4000 && (alt ? rsp_valid2 : rsp_valid) !== 1'b1);
    if (n >= 4000) fail_count++;
  endtask : run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // watchdog well beyond the length of all commands
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
  // command sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = pre(i[7:0]);
    end
    repeat (4) @(posedge core_clk);
    #2;
    rst = 1'b0;
    run(1'b1, 1'b1, 8'h10, 16'h1234, 1'b0);
    cmp_b("write nack", 1'b0, rsp_nack);
    cmp_w("reg 10", 16'h1234, regs[8'h10]);
    cmp_b("busy after write", 1'b0, xfer_active);
    cmp_b("ready after write", 1'b1, cmd_ready);
    run(1'b0, 1'b1, 8'h10, 16'h0000, 1'b0);
    cmp_w("read 10", 16'h1234, rsp_rdata);
    foreach (rd_addr[k]) begin
      run(1'b0, 1'b1, rd_addr[k], 16'h0000, 1'b0);
      cmp_w("read map", pre(rd_addr[k]), rsp_rdata);
    end
    run(1'b1, 1'b1, 8'h20, 16'h0a0b, 1'b0);
    cmp_w("pointer", 16'h0021, {8'h00, reg_addr});
    run(1'b0, 1'b0, 8'h00, 16'h0000, 1'b0);
    cmp_w("read last", pre(8'h21), rsp_rdata);
    write_only = 1'b1;
    run(1'b0, 1'b1, 8'h02, 16'h0000, 1'b0);
    cmp_b("write only read", 1'b1, rsp_nack);
    run(1'b1, 1'b1, 8'h03, 16'h5555, 1'b0);
    cmp_w("write only write", 16'h5555, regs[8'h03]);
    write_only = 1'b0;
    busy = 1'b1;
    run(1'b1, 1'b1, 8'h30, 16'hffff, 1'b0);
    cmp_w("blocked write", pre(8'h30), regs[8'h30]);
    cmp_b("refused pulse", 1'b1, refused_seen);
    run(1'b0, 1'b1, 8'h02, 16'h0000, 1'b0);
    cmp_w("blocked read", 16'h0000, rsp_rdata);
    foreach (open_addr[k]) begin
      run(1'b1, 1'b1, open_addr[k], 16'h0f0f, 1'b0);
      cmp_w("open write", 16'h0f0f, regs[open_addr[k]]);
    end
    busy = 1'b0;
    for (int m = 0; m < 2; m++) begin
      mclk_assured = m[0];
      run(1'b1, 1'b1, `TWR_CLK_REG, 16'hffff, 1'b0);
      cmp_w("clock enable", m[0] ? 16'hffff : ~`TWR_SYS_CLK_EN_MASK, regs[`TWR_CLK_REG]);
    end
    run(1'b1, 1'b1, 8'h40, 16'h1111, 1'b1);
    cmp_b("foreign id nack", 1'b1, rsp_nack2);
    cmp_b("foreign id write", 1'b0, we2_seen);
    conclude();
  end
endmodule : two_wire_register_slave_test

/* File: testbench/twr_link_asserts.sv */
// assertions on the link wires between host end and device end
// assumes plain copies of the link signals, sampled in the core clock domain
`timescale 1ns/1ps
`include "twr_defs.svh"
module twr_link_asserts #(
  parameter int         QTR_CYC = `TWR_QTR_CYC,
  parameter logic [7:0] DEV_ID  = `TWR_DEV_ID  // arbitrary identifier
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic       scl_ff, sda_ff, first_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff, hi_ff;
  // edges, conditions and the acknowledge slot of the first byte
  wire        rise      = scl & ~scl_ff;
  wire        start     = scl & scl_ff & ~sda & sda_ff;
  wire        stop      = scl & scl_ff & sda & ~sda_ff;
  wire        ack       = rise & (bit_ff == 4'h8) & first_ff;
  wire [3:0]  nxt_bit   = start ? 4'h0 : !rise ? bit_ff : (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
  wire        nxt_first = start | (first_ff & ~ack);
  wire [7:0]  nxt_sh    = rise ? {sh_ff[6:0], sda} : sh_ff;
  wire [7:0]  nxt_hi    = !scl ? 8'h00 : (hi_ff == 8'hff) ? hi_ff : hi_ff + 8'h01;
  // wire history, bit position since start, clock high time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      first_ff <= 1'b0;
      bit_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      hi_ff    <= 8'hff;
    end else begin
      scl_ff   <= scl;
      sda_ff   <= sda;
      first_ff <= nxt_first;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      hi_ff    <= nxt_hi;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  chk_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives data line high");
  chk_dev_steady_high: assert property (scl && scl_ff |-> $stable(dev_sda_oe))
    else $error("device changes data line while clock high");
  chk_ack_in_low: assert property ($rose(dev_sda_oe) |-> !scl ##1 dev_sda_oe[*3])
    else $error("device pull not placed in clock low phase");
  chk_id_matches: assert property (ack |-> sh_ff[7:1] == DEV_ID[7:1])
    else $error("first byte after start is not the identifier");
  chk_id_acked: assert property (ack && !sh_ff[0] |-> !sda)
    else $error("write identifier not acknowledged");
  chk_start_framed: assert property (start |-> ##[1:40] !scl)
    else $error("no clock after start");
  chk_stop_idle: assert property (stop |-> (scl && sda)[*3])
    else $error("link not idle after stop");
  chk_scl_high_time: assert property ($fell(scl) |-> hi_ff >= 2 * QTR_CYC)
    else $error("clock high phase too short");
endmodule : twr_link_asserts

/* File: verilog/twr_defs.svh */
// constants shared by both ends of the two-wire register link
// assumes the including file is compiled after twr_pkg
//
// Overview of operation
// - fixed bus identifier, separate from register addresses
// - identifier LSB: 1 reads, 0 writes
// - device sends one by releasing data line
// - master opens every transfer with start condition
// - device shifts eight identifier bits, MSB first
// - matching identifier acknowledged by pulling data low
// - mismatch or write-only read: idle, no acknowledge
// - master ends every transfer with stop condition
// - completed transaction returns device to idle
// - unexpected data change while clock high: idle
// - register address byte follows identifier byte
// - every register readable over the link; blocked registers read as zero while busy, no reads when write-only
// - host keeps system clock enable zero unassured
// - single and auto-increment multiple reads and writes
// - read: address, repeated start, read identifier, nack
// - device is slave only, clock is input
// - address-less read continues from last register
// - sequencer busy blocks all but sequencer, reset
`ifndef TWR_DEFS_SVH
`define TWR_DEFS_SVH

// bus identifier with direction bit clear; value is arbitrary
`define TWR_DEV_ID      8'h5a
// bit count that closes a byte, acknowledge slot follows
`define TWR_BIT_LAST    4'h8
// registers still reachable while the sequencer is busy
`define TWR_SEQ_LO      8'h6c
`define TWR_SEQ_HI      8'h70
`define TWR_SWRST_ADDR  8'h00
// register and bit holding the system clock enable
`define TWR_CLK_REG     8'h01
`define TWR_SYS_CLK_EN_MASK 16'h0001
// timing: core clock and serial clock periods in ns
`define TWR_CLK_NS      20
`define TWR_SCL_NS      2500
// quarter serial period in core cycles, rounded up
`define TWR_QTR_CYC     ((`TWR_SCL_NS + 4 * `TWR_CLK_NS - 1) / (4 * `TWR_CLK_NS))

`endif

/* File: verilog/twr_dev_end.sv */
// device end of the two-wire register link: slave that reads and writes
// a 16-bit wide, 8-bit addressed register map
// assumes the map answers reg_rdata combinationally for reg_addr, and that
// the link pins are asynchronous to core_clk
`timescale 1ns/1ps
`include "twr_defs.svh"
module twr_dev_end #(
  parameter logic [7:0] DEV_ID = `TWR_DEV_ID  // arbitrary identifier
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  twr_if.dev                     bus,
  input  wire logic              write_only,
  input  wire logic              sequencer_busy_flag,
  output logic                   xfer_active,
  output twr_pkg::twr_byte_t     reg_addr,
  input  wire twr_pkg::twr_word_t reg_rdata,
  output twr_pkg::twr_word_t     reg_wdata,
  output logic                   reg_we,
  output logic                   access_refused
);
  import twr_pkg::*;

  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] flt_ff;
  logic [1:0] prv_ff;
  logic [1:0] nxt_flt;
  twr_dst_e   st_ff;
  twr_dst_e   nxt_st;
  twr_kind_e  kind_ff;
  twr_kind_e  nxt_kind;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  twr_byte_t  shift_ff;
  twr_byte_t  nxt_shift;
  logic       rw_ff;
  logic       nxt_rw;
  twr_byte_t  high_data_byte_ff;
  twr_byte_t  nxt_high_data_byte;
  twr_word_t  word_ff;
  twr_word_t  nxt_word;
  twr_byte_t  ptr_ff;
  twr_byte_t  nxt_ptr;
  logic       drive_ff;
  logic       nxt_drive;
  logic       mack_ff;
  logic       nxt_mack;
  logic       we_ff;
  logic       nxt_we;
  logic       refused_ff;
  logic       nxt_refused;
  twr_word_t  wdata_ff;
  twr_word_t  nxt_wdata;

  wire logic      scl_rise;
  wire logic      scl_fall;
  wire logic      start_det;
  wire logic      stop_det;
  wire logic      start_ok;
  wire logic      byte_done;
  wire logic      id_ok;
  wire logic      ptr_ok;
  wire twr_word_t rd_word;
  wire twr_byte_t ptr_inc;

  // registers open to the link, given the sequencer state
  function automatic logic access_ok(input twr_byte_t a, input logic busy);
    access_ok = !busy || (a >= `TWR_SEQ_LO && a <= `TWR_SEQ_HI) || a == `TWR_SWRST_ADDR;
  endfunction : access_ok

  // pin synchroniser, three stages, a level counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_ff  <= 2'h3;
      s2_ff  <= 2'h3;
      s3_ff  <= 2'h3;
      flt_ff <= 2'h3;
      prv_ff <= 2'h3;
    end else begin
      s1_ff  <= {bus.scl, bus.sda};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= nxt_flt;
      prv_ff <= flt_ff;
    end
  end

  // filtered levels and edges; index 1 is the clock, 0 the data line
  assign nxt_flt   = (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
  assign scl_rise  = flt_ff[1] & ~prv_ff[1];
  assign scl_fall  = ~flt_ff[1] & prv_ff[1];
  assign start_det = flt_ff[1] & prv_ff[1] & prv_ff[0] & ~flt_ff[0];
  assign stop_det  = flt_ff[1] & prv_ff[1] & ~prv_ff[0] & flt_ff[0];

  // byte decode and register map selection
  assign byte_done = cnt_ff == `TWR_BIT_LAST;
  assign id_ok     = shift_ff[7:1] == DEV_ID[7:1] && !(shift_ff[0] && write_only);
  assign start_ok  = st_ff == DS_IDLE
                     || (st_ff == DS_RX && kind_ff == K_HI && cnt_ff <= 4'h1 && !rw_ff);
  assign ptr_ok    = access_ok(ptr_ff, sequencer_busy_flag);
  assign rd_word   = ptr_ok ? reg_rdata : 16'h0000;
  assign ptr_inc   = 8'(ptr_ff + 8'h01);

  // next-state logic of the byte engine
  always_comb begin
    nxt_st             = st_ff;
    nxt_kind           = kind_ff;
    nxt_cnt            = cnt_ff;
    nxt_shift          = shift_ff;
    nxt_rw             = rw_ff;
    nxt_high_data_byte = high_data_byte_ff;
    nxt_word           = word_ff;
    nxt_ptr            = ptr_ff;
    nxt_drive          = drive_ff;
    nxt_mack           = mack_ff;
    nxt_we             = 1'h0;
    nxt_refused        = 1'h0;
    nxt_wdata          = wdata_ff;
    if (stop_det) begin
      nxt_st    = DS_IDLE;
      nxt_drive = 1'h0;
    end else if (start_det) begin
      nxt_drive = 1'h0;
      nxt_cnt   = 4'h0;
      nxt_kind  = K_ID;
      nxt_st    = start_ok ? DS_RX : DS_IDLE;
    end else begin
      unique case (st_ff)
        DS_IDLE: begin
          nxt_drive = 1'h0;
        end
        DS_RX: begin
          if (scl_rise && !byte_done) begin
            nxt_shift = {shift_ff[6:0], flt_ff[0]};
            nxt_cnt   = 4'(cnt_ff + 4'h1);
          end else if (scl_fall && byte_done) begin
            nxt_st    = DS_ACK;
            nxt_drive = 1'h1;
            nxt_cnt   = 4'h0;
            unique case (kind_ff)
              K_ID: begin
                nxt_rw = shift_ff[0];
                if (!id_ok) begin
                  nxt_st    = DS_IDLE;
                  nxt_drive = 1'h0;
                end
              end
              K_ADDR: nxt_ptr = shift_ff;
              K_HI: nxt_high_data_byte = shift_ff;
              K_LO: begin
                nxt_we      = ptr_ok;
                nxt_refused = !ptr_ok;
                nxt_wdata   = {high_data_byte_ff, shift_ff};
              end
            endcase
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            nxt_drive = 1'h0;
            nxt_st    = DS_RX;
            unique case (kind_ff)
              K_ID: begin
                if (rw_ff) begin
                  nxt_st    = DS_TX;
                  nxt_kind  = K_HI;
                  nxt_word  = rd_word;
                  nxt_shift = rd_word[15:8];
                  nxt_drive = ~rd_word[15];
                end else begin
                  nxt_kind = K_ADDR;
                end
              end
              K_ADDR: nxt_kind = K_HI;
              K_HI: nxt_kind = K_LO;
              K_LO: begin
                nxt_kind = K_HI;
                nxt_ptr  = ptr_inc;
              end
            endcase
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            nxt_cnt = 4'(cnt_ff + 4'h1);
          end else if (scl_fall) begin
            if (byte_done) begin
              nxt_st    = DS_MACK;
              nxt_drive = 1'h0;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'h0};
              nxt_drive = ~shift_ff[6];
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            nxt_mack = ~flt_ff[0];
            if (!flt_ff[0] && kind_ff == K_LO) begin
              nxt_ptr = ptr_inc;
            end
          end else if (scl_fall) begin
            nxt_cnt = 4'h0;
            if (!mack_ff) begin
              nxt_st = DS_IDLE;
            end else if (kind_ff == K_HI) begin
              nxt_st    = DS_TX;
              nxt_kind  = K_LO;
              nxt_shift = word_ff[7:0];
              nxt_drive = ~word_ff[7];
            end else begin
              nxt_st    = DS_TX;
              nxt_kind  = K_HI;
              nxt_word  = rd_word;
              nxt_shift = rd_word[15:8];
              nxt_drive = ~rd_word[15];
            end
          end
        end
        default: begin
          nxt_st    = DS_IDLE;
          nxt_drive = 1'h0;
        end
      endcase
    end
  end

  // state registers of the byte engine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff             <= DS_IDLE;
      kind_ff           <= K_ID;
      cnt_ff            <= 4'h0;
      shift_ff          <= 8'h00;
      rw_ff             <= 1'h0;
      high_data_byte_ff <= 8'h00;
      word_ff           <= 16'h0000;
      ptr_ff            <= 8'h00;
      drive_ff          <= 1'h0;
      mack_ff           <= 1'h0;
    end else begin
      st_ff             <= nxt_st;
      kind_ff           <= nxt_kind;
      cnt_ff            <= nxt_cnt;
      shift_ff          <= nxt_shift;
      rw_ff             <= nxt_rw;
      high_data_byte_ff <= nxt_high_data_byte;
      word_ff           <= nxt_word;
      ptr_ff            <= nxt_ptr;
      drive_ff          <= nxt_drive;
      mack_ff           <= nxt_mack;
    end
  end

  // register write port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      we_ff      <= 1'h0;
      refused_ff <= 1'h0;
      wdata_ff   <= 16'h0000;
    end else begin
      we_ff      <= nxt_we;
      refused_ff <= nxt_refused;
      wdata_ff   <= nxt_wdata;
    end
  end

  // outputs; the data line is only ever pulled low, never driven high
  assign bus.dev_sda_o  = 1'h0;
  assign bus.dev_sda_oe = drive_ff;
  assign xfer_active    = st_ff != DS_IDLE;
  assign reg_addr       = ptr_ff;
  assign reg_wdata      = wdata_ff;
  assign reg_we         = we_ff;
  assign access_refused = refused_ff;
endmodule : twr_dev_end

/* File: verilog/twr_host_end.sv */
// host end of the two-wire register link: bus master running single
// register writes and reads, clock made from core_clk by a divider
// assumes one command at a time on the user side
`timescale 1ns/1ps
`include "twr_defs.svh"
module twr_host_end #(
  parameter int         QTR_CYC = `TWR_QTR_CYC,
  parameter logic [7:0] DEV_ID  = `TWR_DEV_ID  // arbitrary identifier
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  twr_if.host                    bus,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire logic              cmd_use_addr,
  input  wire twr_pkg::twr_byte_t cmd_addr,
  input  wire twr_pkg::twr_word_t cmd_wdata,
  input  wire logic              mclk_assured,
  output logic                   rsp_valid,
  output logic                   rsp_nack,
  output twr_pkg::twr_word_t     rsp_rdata
);
  import twr_pkg::*;

  localparam logic [15:0] QTR_M1 = 16'(QTR_CYC - 1);

  logic [2:0] sy_ff;
  logic       sda_ff;
  twr_hst_e   st_ff;
  twr_hst_e   nxt_st;
  twr_step_e  step_ff;
  twr_step_e  nxt_step;
  logic [1:0] ph_ff;
  logic [15:0] q_ff;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  twr_byte_t  tx_ff;
  twr_byte_t  nxt_tx;
  twr_word_t  rx_ff;
  twr_word_t  nxt_rx;
  logic       nack_ff;
  logic       nxt_nack;
  logic       wr_ff;
  logic       ua_ff;
  twr_byte_t  addr_ff;
  twr_word_t  wdata_ff;
  logic       scl_ff;
  logic       rel_ff;
  logic       done_ff;
  twr_word_t  rdata_ff;

  wire logic      tick;
  wire logic      smp;
  wire logic      unit_end;
  wire logic      is_cond;
  wire logic      rx_byte;
  wire logic      last_bit;
  wire logic      scl_val;
  wire logic      rel_val;
  wire twr_step_e after_step;
  wire twr_word_t wmask;

  // step that follows the current one for this command
  function automatic twr_step_e step_after(input twr_step_e s, input logic wr, input logic ua);
    unique case (s)
      ST_START:  step_after = ua ? ST_IDW : ST_IDR;
      ST_IDW:    step_after = ST_ADDR;
      ST_ADDR:   step_after = wr ? ST_HI : ST_RSTART;
      ST_RSTART: step_after = ST_IDR;
      ST_IDR:    step_after = ST_HI;
      ST_HI:     step_after = ST_LO;
      ST_LO:     step_after = ST_STOP;
      ST_STOP:   step_after = ST_STOP;
    endcase
  endfunction : step_after

  // byte the host sends in a step; all ones releases the line for reading
  function automatic twr_byte_t byte_of(input twr_step_e s, input logic wr, input twr_byte_t a,
                                        input twr_word_t d);
    unique case (s)
      ST_IDW:  byte_of = {DEV_ID[7:1], 1'h0};
      ST_IDR:  byte_of = {DEV_ID[7:1], 1'h1};
      ST_ADDR: byte_of = a;
      ST_HI:   byte_of = wr ? d[15:8] : 8'hff;
      ST_LO:   byte_of = wr ? d[7:0] : 8'hff;
      default: byte_of = 8'hff;
    endcase
  endfunction : byte_of

  // data line synchroniser, a level counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sy_ff  <= 3'h7;
      sda_ff <= 1'h1;
    end else begin
      sy_ff  <= {sy_ff[1:0], bus.sda};
      sda_ff <= (sy_ff[2] == sy_ff[1]) ? sy_ff[2] : sda_ff;
    end
  end

  // phase timing and step decode
  assign tick       = q_ff == QTR_M1;
  assign smp        = tick && ph_ff == 2'h1;
  assign unit_end   = tick && ph_ff == 2'h3;
  assign is_cond    = step_ff == ST_START || step_ff == ST_RSTART || step_ff == ST_STOP;
  assign rx_byte    = !wr_ff && (step_ff == ST_HI || step_ff == ST_LO);
  assign last_bit   = bit_ff == `TWR_BIT_LAST;
  assign after_step = nack_ff ? ST_STOP : step_after(step_ff, wr_ff, ua_ff);
  assign wmask      = (!mclk_assured && cmd_addr == `TWR_CLK_REG)
                      ? (cmd_wdata & ~`TWR_SYS_CLK_EN_MASK) : cmd_wdata;

  // wanted pin levels: start high-high-low-low, stop low-low-high-high
  assign scl_val = (st_ff == HS_IDLE) ? 1'h1
                 : (step_ff == ST_STOP) ? (ph_ff != 2'h0) : (ph_ff[0] ^ ph_ff[1]);
  assign rel_val = (st_ff == HS_IDLE) ? 1'h1
                 : (step_ff == ST_STOP) ? ph_ff[1]
                 : is_cond ? ~ph_ff[1]
                 : last_bit ? (rx_byte ? (step_ff == ST_LO) : 1'h1)
                 : (rx_byte ? 1'h1 : tx_ff[7]);

  // next-state logic of the sequencer
  always_comb begin
    nxt_st   = st_ff;
    nxt_step = step_ff;
    nxt_bit  = bit_ff;
    nxt_tx   = tx_ff;
    nxt_rx   = rx_ff;
    nxt_nack = nack_ff;
    if (st_ff == HS_IDLE) begin
      if (cmd_valid) begin
        nxt_st   = HS_RUN;
        nxt_step = ST_START;
        nxt_bit  = 4'h0;
        nxt_nack = 1'h0;
      end
    end else begin
      if (smp && !is_cond && !last_bit && rx_byte) begin
        nxt_rx = {rx_ff[14:0], sda_ff};
      end
      if (smp && !is_cond && last_bit && !rx_byte && sda_ff) begin
        nxt_nack = 1'h1;
      end
      if (unit_end) begin
        if (is_cond || last_bit) begin
          nxt_bit = 4'h0;
          if (step_ff == ST_STOP) begin
            nxt_st = HS_IDLE;
          end else begin
            nxt_step = after_step;
            nxt_tx   = byte_of(after_step, wr_ff, addr_ff, wdata_ff);
          end
        end else begin
          nxt_bit = 4'(bit_ff + 4'h1);
          nxt_tx  = {tx_ff[6:0], 1'h1};
        end
      end
    end
  end

  // sequencer registers and registered pin drive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff   <= HS_IDLE;
      step_ff <= ST_START;
      ph_ff   <= 2'h0;
      q_ff    <= 16'h0000;
      bit_ff  <= 4'h0;
      tx_ff   <= 8'hff;
      rx_ff   <= 16'h0000;
      nack_ff <= 1'h0;
      scl_ff  <= 1'h1;
      rel_ff  <= 1'h1;
    end else begin
      st_ff   <= nxt_st;
      step_ff <= nxt_step;
      ph_ff   <= (st_ff == HS_RUN && tick) ? 2'(ph_ff + 2'h1) : ph_ff;
      q_ff    <= (st_ff == HS_IDLE || tick) ? 16'h0000 : 16'(q_ff + 16'h0001);
      bit_ff  <= nxt_bit;
      tx_ff   <= nxt_tx;
      rx_ff   <= nxt_rx;
      nack_ff <= nxt_nack;
      scl_ff  <= scl_val;
      rel_ff  <= rel_val;
    end
  end

  // command capture and answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ff    <= 1'h0;
      ua_ff    <= 1'h0;
      addr_ff  <= 8'h00;
      wdata_ff <= 16'h0000;
      done_ff  <= 1'h0;
      rdata_ff <= 16'h0000;
    end else begin
      done_ff <= st_ff == HS_RUN && nxt_st == HS_IDLE;
      if (st_ff == HS_IDLE && cmd_valid) begin
        wr_ff    <= cmd_write;
        ua_ff    <= cmd_write | cmd_use_addr;
        addr_ff  <= cmd_addr;
        wdata_ff <= wmask;
      end
      if (st_ff == HS_RUN && nxt_st == HS_IDLE) begin
        rdata_ff <= wr_ff ? 16'h0000 : rx_ff;
      end
    end
  end

  assign cmd_ready       = st_ff == HS_IDLE;
  assign bus.scl         = scl_ff;
  assign bus.host_sda_o  = 1'h0;
  assign bus.host_sda_oe = ~rel_ff;
  assign rsp_valid       = done_ff;
  assign rsp_nack        = nack_ff;
  assign rsp_rdata       = rdata_ff;
endmodule : twr_host_end

/* File: verilog/twr_if.sv */
// two-wire link between host end and device end
// data line is open-drain with a pull-up; clock is driven by the host only
`timescale 1ns/1ps
interface twr_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // wired level: low when any enabled driver pulls low, else pulled high
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface : twr_if

/* File: verilog/twr_pkg.sv */
// types for the two-wire register link
// assumes nothing of its surroundings
package twr_pkg;

  typedef logic [7:0]  twr_byte_t;
  typedef logic [15:0] twr_word_t;

  // device end states
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_RX   = 3'h1,
    DS_ACK  = 3'h2,
    DS_TX   = 3'h3,
    DS_MACK = 3'h4
  } twr_dst_e;

  // which byte of a transaction is in flight
  typedef enum logic [1:0] {
    K_ID   = 2'h0,
    K_ADDR = 2'h1,
    K_HI   = 2'h2,
    K_LO   = 2'h3
  } twr_kind_e;

  // host end states
  typedef enum logic {
    HS_IDLE = 1'h0,
    HS_RUN  = 1'h1
  } twr_hst_e;

  // host transaction steps
  typedef enum logic [2:0] {
    ST_START  = 3'h0,
    ST_IDW    = 3'h1,
    ST_ADDR   = 3'h2,
    ST_RSTART = 3'h3,
    ST_IDR    = 3'h4,
    ST_HI     = 3'h5,
    ST_LO     = 3'h6,
    ST_STOP   = 3'h7
  } twr_step_e;

endpackage : twr_pkg
